//--- hdl/t8w_defs.svh
`ifndef T8W_DEFS_SVH
`define T8W_DEFS_SVH

// ---------------------------------------------------------------
// register byte offsets (low eight address bits)
// ---------------------------------------------------------------
`define T8W_OFF_CTRL_A   8'h24
`define T8W_OFF_CTRL_B   8'h28
`define T8W_OFF_CMP_A    8'h2C
`define T8W_OFF_CMP_B    8'h30
`define T8W_OFF_COUNT    8'h34
`define T8W_OFF_STATUS   8'h38
`define T8W_OFF_PORT     8'h3C

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define T8W_ACT_A_HI     7
`define T8W_ACT_A_LO     6
`define T8W_ACT_B_HI     5
`define T8W_ACT_B_LO     4
`define T8W_WAVE_LO_HI   1
`define T8W_WAVE_LO_LO   0
`define T8W_HIGH_BIT     0
`define T8W_RUN_BIT      1
`define T8W_WRAP_BIT     0
`define T8W_DIR_BIT      1
`define T8W_DDR_A_BIT    0
`define T8W_DDR_B_BIT    1
`define T8W_DATA_A_BIT   2
`define T8W_DATA_B_BIT   3

// ---------------------------------------------------------------
// reset values and counter landmarks
// ---------------------------------------------------------------
`define T8W_RST_BYTE     8'h00
`define T8W_RST_WORD     32'h00000000
`define T8W_MAX          8'hFF
`define T8W_BOTTOM       8'h00
`define T8W_STEP         8'h01

// ---------------------------------------------------------------
// waveform mode codes and compare output action codes
// ---------------------------------------------------------------
`define T8W_MODE_NORMAL  3'h0
`define T8W_MODE_PHASE_M 3'h1
`define T8W_MODE_CLRMAT  3'h2
`define T8W_MODE_FAST_M  3'h3
`define T8W_MODE_RSVD4   3'h4
`define T8W_MODE_PHASE_A 3'h5
`define T8W_MODE_RSVD6   3'h6
`define T8W_MODE_FAST_A  3'h7
`define T8W_ACT_OFF      2'h0
`define T8W_ACT_TOGGLE   2'h1
`define T8W_ACT_CLEAR    2'h2
`define T8W_ACT_SET      2'h3

`endif

//--- hdl/t8w_pkg.sv
package t8w_pkg;
	// counting class derived from the waveform mode
	typedef enum logic [1:0] {
		T8W_CLS_PLAIN = 2'b00,
		T8W_CLS_FAST  = 2'b01,
		T8W_CLS_PHASE = 2'b10
	} t8w_cls_t;
	typedef logic [1:0] t8w_action_t;
	typedef logic [7:0] t8w_byte_t;
endpackage

//--- hdl/t8w_wave_if.sv
`timescale 1ns/1ps
`default_nettype none
// shared counter view handed from the timer core to each channel
interface t8w_wave_if;
	import t8w_pkg::*;
	logic      tick;
	t8w_byte_t count;
	t8w_byte_t top;
	t8w_cls_t  cls;
	logic      up;
	logic      high_bit;
	modport src (output tick, output count, output top, output cls, output up, output high_bit);
	modport snk (input tick, input count, input top, input cls, input up, input high_bit);
endinterface
`default_nettype wire

//--- hdl/t8w_chan.sv
`timescale 1ns/1ps
`default_nettype none
`include "t8w_defs.svh"
module t8w_chan #(
	parameter bit IS_CHAN_A = 1'b1
) (
	// counter view
	t8w_wave_if.snk             wv,
	// clock and reset
	input  wire logic           clk_sys,
	input  wire logic           rst,
	// channel settings
	input  wire t8w_pkg::t8w_action_t action,
	input  wire t8w_pkg::t8w_byte_t   cmp,
	// results
	output logic                wave,
	output logic                connect
);
	import t8w_pkg::*;

	logic match;
	logic at_top;
	logic cmp_is_top;
	logic toggle_ok;
	logic next_wave;

	// match events only count on a timer tick
	assign match      = wv.tick && (wv.count == cmp);
	assign at_top     = wv.tick && (wv.count == wv.top);
	assign cmp_is_top = (cmp == wv.top) && action[1];
	// toggle in pwm classes needs channel a and the high mode bit
	assign toggle_ok  = (wv.cls == T8W_CLS_PLAIN) || (IS_CHAN_A && wv.high_bit);

	// pin takeover: any nonzero code, except a disabled pwm toggle
	always_comb begin
		connect = (action != `T8W_ACT_OFF);
		if (action == `T8W_ACT_TOGGLE && !toggle_ok) begin
			connect = 1'b0;
		end
	end

	// waveform next value per class and action
	always_comb begin
		next_wave = wave;
		case (wv.cls)
			T8W_CLS_FAST: begin
				if (action == `T8W_ACT_TOGGLE) begin
					if (toggle_ok && match) next_wave = ~wave;
				end else if (action[1]) begin
					// a match at top is dropped; the wrap edge does the work
					if (match && !cmp_is_top) next_wave = action[0];
					if (at_top) next_wave = action[0] ^ 1'b1 ? 1'b1 : 1'b0;
				end
			end
			T8W_CLS_PHASE: begin
				if (action == `T8W_ACT_TOGGLE) begin
					if (toggle_ok && match) next_wave = ~wave;
				end else if (action[1]) begin
					if (cmp_is_top) begin
						// same level as a down-counting match, held from top
						if (at_top) next_wave = ~action[0] ? 1'b1 : 1'b0;
					end else if (match) begin
						next_wave = wv.up ? action[0] : ~action[0];
					end
				end
			end
			default: begin
				if (match) begin
					case (action)
						`T8W_ACT_TOGGLE: next_wave = ~wave;
						`T8W_ACT_CLEAR:  next_wave = 1'b0;
						`T8W_ACT_SET:    next_wave = 1'b1;
						default:         next_wave = wave;
					endcase
				end
			end
		endcase
	end

	// waveform state keeps its level while disconnected
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			wave <= 1'b0;
		end else begin
			wave <= next_wave;
		end
	end
endmodule
`default_nettype wire

//--- hdl/t8w_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "t8w_defs.svh"
module t8w_top #(
	parameter int ADDR_W = 12
) (
	// clock and reset
	input  wire logic              clk_sys,
	input  wire logic              rst,
	// apb slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic                   pready,
	output logic [31:0]            prdata,
	output logic                   pslverr,
	// pins
	output logic                   chan_a_wave_out,
	output logic                   chan_a_drive_en_n,
	output logic                   chan_b_wave_out,
	output logic                   chan_b_drive_en_n,
	// status
	output logic                   wrap_flag
);
	import t8w_pkg::*;

	// ---------------------------------------------------------------
	// elaboration checks
	// ---------------------------------------------------------------
	if (ADDR_W < 8) begin : g_bad_addr
		$error("ADDR_W must be at least 8");
	end

	// ---------------------------------------------------------------
	// register state
	// ---------------------------------------------------------------
	t8w_action_t chan_a_output_action;
	t8w_action_t chan_b_output_action;
	logic [1:0]  wave_mode_low_bits;
	logic        wave_mode_high_bit;
	logic        run;
	t8w_byte_t   chan_a_compare_value;
	t8w_byte_t   chan_b_compare_value;
	t8w_byte_t   cmp_a_act;
	t8w_byte_t   cmp_b_act;
	logic        ddr_a;
	logic        ddr_b;
	logic        port_a_data;
	logic        port_b_data;

	// counter state
	t8w_byte_t   count_value;
	logic        count_up;

	// derived
	logic [2:0]  wave_mode;
	t8w_cls_t    cls;
	t8w_byte_t   top_val;
	logic        tick;
	logic        at_top;
	logic        wrap_set;
	t8w_byte_t   next_count;
	logic        next_up;

	// apb decode
	logic        acc;
	logic        wr_fire;
	logic        addr_hi_zero;
	logic [7:0]  addr_lo;
	logic [31:0] rd_word;
	logic        rd_hit;

	// channel results
	logic        wave_a;
	logic        wave_b;
	logic        connect_a;
	logic        connect_b;

	t8w_wave_if wv ();

	// ---------------------------------------------------------------
	// apb slave: one wait state, answer registered
	// ---------------------------------------------------------------
	assign acc          = psel && penable;
	assign wr_fire      = acc && pready && pwrite;
	assign addr_lo      = paddr[7:0];
	assign addr_hi_zero = (paddr >> 8) == '0;

	// read mux; reserved control bits stay zero
	always_comb begin
		rd_word = `T8W_RST_WORD;
		rd_hit  = addr_hi_zero;
		if (addr_hi_zero) begin
			case (addr_lo)
				`T8W_OFF_CTRL_A: begin
					rd_word[`T8W_ACT_A_HI:`T8W_ACT_A_LO]     = chan_a_output_action;
					rd_word[`T8W_ACT_B_HI:`T8W_ACT_B_LO]     = chan_b_output_action;
					rd_word[`T8W_WAVE_LO_HI:`T8W_WAVE_LO_LO] = wave_mode_low_bits;
				end
				`T8W_OFF_CTRL_B: begin
					rd_word[`T8W_HIGH_BIT] = wave_mode_high_bit;
					rd_word[`T8W_RUN_BIT]  = run;
				end
				`T8W_OFF_CMP_A:  rd_word[7:0] = chan_a_compare_value;
				`T8W_OFF_CMP_B:  rd_word[7:0] = chan_b_compare_value;
				`T8W_OFF_COUNT:  rd_word[7:0] = count_value;
				`T8W_OFF_STATUS: begin
					rd_word[`T8W_WRAP_BIT] = wrap_flag;
					rd_word[`T8W_DIR_BIT]  = count_up;
				end
				`T8W_OFF_PORT: begin
					rd_word[`T8W_DDR_A_BIT]  = ddr_a;
					rd_word[`T8W_DDR_B_BIT]  = ddr_b;
					rd_word[`T8W_DATA_A_BIT] = port_a_data;
					rd_word[`T8W_DATA_B_BIT] = port_b_data;
				end
				default: rd_hit = 1'b0;
			endcase
		end
	end

	// ready rises one cycle into the access phase, then drops
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pready  <= 1'b0;
			prdata  <= `T8W_RST_WORD;
			pslverr <= 1'b0;
		end else begin
			pready  <= acc && !pready;
			pslverr <= acc && !pready && !rd_hit;
			if (acc && !pready && !pwrite) begin
				prdata <= rd_word;
			end
		end
	end

	// ---------------------------------------------------------------
	// software registers
	// ---------------------------------------------------------------
	// control and port registers; a refused address changes nothing
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			chan_a_output_action <= `T8W_ACT_OFF;
			chan_b_output_action <= `T8W_ACT_OFF;
			wave_mode_low_bits   <= 2'(`T8W_MODE_NORMAL);
			wave_mode_high_bit   <= 1'b0;
			run                  <= 1'b0;
			ddr_a                <= 1'b0;
			ddr_b                <= 1'b0;
			port_a_data          <= 1'b0;
			port_b_data          <= 1'b0;
		end else if (wr_fire && addr_hi_zero) begin
			case (addr_lo)
				`T8W_OFF_CTRL_A: begin
					chan_a_output_action <= pwdata[`T8W_ACT_A_HI:`T8W_ACT_A_LO];
					chan_b_output_action <= pwdata[`T8W_ACT_B_HI:`T8W_ACT_B_LO];
					wave_mode_low_bits   <= pwdata[`T8W_WAVE_LO_HI:`T8W_WAVE_LO_LO];
				end
				`T8W_OFF_CTRL_B: begin
					wave_mode_high_bit <= pwdata[`T8W_HIGH_BIT];
					run                <= pwdata[`T8W_RUN_BIT];
				end
				`T8W_OFF_PORT: begin
					ddr_a       <= pwdata[`T8W_DDR_A_BIT];
					ddr_b       <= pwdata[`T8W_DDR_B_BIT];
					port_a_data <= pwdata[`T8W_DATA_A_BIT];
					port_b_data <= pwdata[`T8W_DATA_B_BIT];
				end
				default: ;
			endcase
		end
	end

	// compare values as software sees them
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			chan_a_compare_value <= `T8W_RST_BYTE;
			chan_b_compare_value <= `T8W_RST_BYTE;
		end else if (wr_fire && addr_hi_zero) begin
			if (addr_lo == `T8W_OFF_CMP_A) chan_a_compare_value <= pwdata[7:0];
			if (addr_lo == `T8W_OFF_CMP_B) chan_b_compare_value <= pwdata[7:0];
		end
	end

	// ---------------------------------------------------------------
	// mode decode
	// ---------------------------------------------------------------
	assign wave_mode = {wave_mode_high_bit, wave_mode_low_bits};
	assign tick      = run;
	assign at_top    = tick && (count_value == top_val);

	// counting class and top source; reserved codes fall back to normal
	always_comb begin
		case (wave_mode)
			`T8W_MODE_PHASE_M: begin
				cls     = T8W_CLS_PHASE;
				top_val = `T8W_MAX;
			end
			`T8W_MODE_CLRMAT: begin
				cls     = T8W_CLS_PLAIN;
				top_val = cmp_a_act;
			end
			`T8W_MODE_FAST_M: begin
				cls     = T8W_CLS_FAST;
				top_val = `T8W_MAX;
			end
			`T8W_MODE_PHASE_A: begin
				cls     = T8W_CLS_PHASE;
				top_val = cmp_a_act;
			end
			`T8W_MODE_FAST_A: begin
				cls     = T8W_CLS_FAST;
				top_val = cmp_a_act;
			end
			default: begin
				cls     = T8W_CLS_PLAIN;
				top_val = `T8W_MAX;
			end
		endcase
	end

	// ---------------------------------------------------------------
	// compare double buffer
	// ---------------------------------------------------------------
	// pwm classes load only at the top-to-bottom turn so a period never
	// sees a half-updated duty; plain modes follow within one cycle
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cmp_a_act <= `T8W_RST_BYTE;
			cmp_b_act <= `T8W_RST_BYTE;
		end else if (cls == T8W_CLS_PLAIN || at_top) begin
			cmp_a_act <= chan_a_compare_value;
			cmp_b_act <= chan_b_compare_value;
		end
	end

	// ---------------------------------------------------------------
	// counter
	// ---------------------------------------------------------------
	always_comb begin
		next_count = count_value;
		next_up    = 1'b1;
		case (cls)
			T8W_CLS_PHASE: begin
				next_up = count_up;
				if (tick) begin
					if (count_up && count_value >= top_val) begin
						next_up    = 1'b0;
						next_count = (count_value == `T8W_BOTTOM) ? count_value : count_value - `T8W_STEP;
					end else if (!count_up && count_value == `T8W_BOTTOM) begin
						next_up    = 1'b1;
						next_count = count_value + `T8W_STEP;
					end else if (count_up) begin
						next_count = count_value + `T8W_STEP;
					end else begin
						next_count = count_value - `T8W_STEP;
					end
				end
			end
			T8W_CLS_FAST: begin
				if (tick) begin
					next_count = at_top ? `T8W_BOTTOM : count_value + `T8W_STEP;
				end
			end
			default: begin
				// clear-on-match wraps at its top, normal just rolls over
				if (tick) begin
					next_count = at_top ? `T8W_BOTTOM : count_value + `T8W_STEP;
				end
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			count_value <= `T8W_BOTTOM;
			count_up    <= 1'b1;
		end else begin
			count_value <= next_count;
			count_up    <= next_up;
		end
	end

	// ---------------------------------------------------------------
	// wrap flag: set wins over a write-one clear in the same cycle
	// ---------------------------------------------------------------
	always_comb begin
		case (wave_mode)
			`T8W_MODE_PHASE_M,
			`T8W_MODE_PHASE_A: wrap_set = tick && !count_up && (count_value == `T8W_BOTTOM);
			`T8W_MODE_FAST_A:  wrap_set = at_top;
			default:           wrap_set = tick && (count_value == `T8W_MAX);
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			wrap_flag <= 1'b0;
		end else if (wrap_set) begin
			wrap_flag <= 1'b1;
		end else if (wr_fire && addr_hi_zero && addr_lo == `T8W_OFF_STATUS && pwdata[`T8W_WRAP_BIT]) begin
			wrap_flag <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// channels
	// ---------------------------------------------------------------
	assign wv.tick     = tick;
	assign wv.count    = count_value;
	assign wv.top      = top_val;
	assign wv.cls      = cls;
	assign wv.up       = count_up;
	assign wv.high_bit = wave_mode_high_bit;

	t8w_chan #(.IS_CHAN_A(1'b1)) u_chan_a (
		.wv      (wv),
		.clk_sys (clk_sys),
		.rst     (rst),
		.action  (chan_a_output_action),
		.cmp     (cmp_a_act),
		.wave    (wave_a),
		.connect (connect_a)
	);

	t8w_chan #(.IS_CHAN_A(1'b0)) u_chan_b (
		.wv      (wv),
		.clk_sys (clk_sys),
		.rst     (rst),
		.action  (chan_b_output_action),
		.cmp     (cmp_b_act),
		.wave    (wave_b),
		.connect (connect_b)
	);

	// ---------------------------------------------------------------
	// pin drive: one cycle behind the waveform state
	// ---------------------------------------------------------------
	// the port value and the waveform share the pin; direction decides
	// whether either of them reaches the outside at all
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			chan_a_wave_out   <= 1'b0;
			chan_b_wave_out   <= 1'b0;
			chan_a_drive_en_n <= 1'b1;
			chan_b_drive_en_n <= 1'b1;
		end else begin
			chan_a_wave_out   <= connect_a ? wave_a : port_a_data;
			chan_b_wave_out   <= connect_b ? wave_b : port_b_data;
			chan_a_drive_en_n <= ~ddr_a;
			chan_b_drive_en_n <= ~ddr_b;
		end
	end
endmodule
`default_nettype wire

//--- testbench/t8w_top_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "t8w_defs.svh"
module t8w_top_monitor #(
	parameter int ADDR_W = 12
) (
	// clock and reset
	input  wire logic              clk_sys,
	input  wire logic              rst,
	// apb slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	input  wire logic              pready,
	input  wire logic [31:0]       prdata,
	input  wire logic              pslverr,
	// pins and status
	input  wire logic              chan_a_wave_out,
	input  wire logic              chan_a_drive_en_n,
	input  wire logic              chan_b_wave_out,
	input  wire logic              chan_b_drive_en_n,
	input  wire logic              wrap_flag
);
	// ---------------------------------------------------------------
	// single clock domain, reset aborts every attempt except a_reset_outputs
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
		else $error("pready missing after one wait state");
	a_ready_one_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_ready_in_access: assert property (pready |-> psel && penable && $past(psel && penable))
		else $error("pready outside an access phase");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_upper_addr_err: assert property (pready && paddr[ADDR_W-1:8] != '0 |-> pslverr)
		else $error("out of range address not refused");
	a_rdata_hold: assert property (!$stable(prdata) |-> pready && !pwrite)
		else $error("prdata changed outside a read answer");
	a_ctrl_reserved_zero: assert property (
		pready && !pwrite && !pslverr && paddr[7:0] == `T8W_OFF_CTRL_A |-> prdata[3:2] == 2'b00 && prdata[31:8] == 24'h0)
		else $error("reserved control bits read nonzero");
	a_wrap_flag_sticky: assert property (
		wrap_flag && !(pready && pwrite && paddr[7:0] == `T8W_OFF_STATUS && pwdata[0]) |=> wrap_flag)
		else $error("wrap flag dropped without a clear");
	a_dir_drive_en: assert property (
		pready && pwrite && !pslverr && paddr[7:0] == `T8W_OFF_PORT |-> ##2
		chan_a_drive_en_n == !$past(pwdata[0], 2) && chan_b_drive_en_n == !$past(pwdata[1], 2))
		else $error("driver enable does not follow direction bits");
	a_reset_outputs: assert property (@(posedge clk_sys) disable iff (1'b0)
		rst |=> chan_a_drive_en_n && chan_b_drive_en_n && !wrap_flag && !pready && !pslverr
		&& !chan_a_wave_out && !chan_b_wave_out)
		else $error("outputs not at reset values");
endmodule
`default_nettype wire

//--- testbench/t8w_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module t8w_pin_model (
	// clock
	input  wire logic clk_sys,
	// drive from the block
	input  wire logic wave_out,
	input  wire logic drive_en_n,
	// resolved pin level
	output logic      pin
);
	logic float_pat = 1'b0;

	// no pull on this pin, so a released pin shows a level that flips each cycle
	always_ff @(posedge clk_sys) begin
		float_pat <= ~float_pat;
	end

	// block drives the pin only while its enable is low
	assign pin = (drive_en_n == 1'b0) ? wave_out : float_pat;
endmodule
`default_nettype wire

//--- testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "t8w_defs.svh"
module testbench;
	logic        clk_sys;
	logic        rst;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic        pready;
	logic [31:0] prdata;
	logic        pslverr;
	logic        wa;
	logic        ena_n;
	logic        wb;
	logic        enb_n;
	logic        wrap_flag;
	logic        pin_a;
	logic        pin_b;
	logic [31:0] d;
	logic        e;
	int          error_cnt;
	int          compares;

	// ---------------------------------------------------------------
	// clock, design and pins
	// ---------------------------------------------------------------
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	t8w_top dut_u (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.chan_a_wave_out(wa), .chan_a_drive_en_n(ena_n), .chan_b_wave_out(wb),
		.chan_b_drive_en_n(enb_n), .wrap_flag(wrap_flag));
	t8w_pin_model pa_u (.clk_sys(clk_sys), .wave_out(wa), .drive_en_n(ena_n), .pin(pin_a));
	t8w_pin_model pb_u (.clk_sys(clk_sys), .wave_out(wb), .drive_en_n(enb_n), .pin(pin_b));

	// ---------------------------------------------------------------
	// checks and bus tasks
	// ---------------------------------------------------------------
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_bit(input string what, input logic exp, input logic got);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %b seen %b", what, exp, got);
		end
	endtask

	// request held until pready is sampled high, then released for one cycle
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		int n;
		n = 0;
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge clk_sys);
		penable <= 1'b1;
		// look at settled outputs mid-cycle; the answer stands up to the next rising edge
		@(negedge clk_sys);
		while (pready !== 1'b1 && n < 16) begin
			@(negedge clk_sys);
			n++;
		end
		rd = prdata;
		err = pslverr;
		if (n >= 16) chk_bit("pready", 1'b1, pready);
		@(posedge clk_sys);
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask

	task automatic wr(input logic [7:0] off, input logic [31:0] wd);
		apb(1'b1, {4'h0, off}, wd, d, e);
		chk_bit("write error", 1'b0, e);
	endtask

	task automatic rd(input logic [7:0] off, output logic [31:0] rd_v);
		apb(1'b0, {4'h0, off}, 32'h00000000, rd_v, e);
		chk_bit("read error", 1'b0, e);
	endtask

	task automatic do_reset();
		rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
	endtask

	// window of 512 cycles spans whole periods of every case below
	task automatic measure(output logic [31:0] ha, ea, hb, eb);
		logic pa;
		logic pb;
		ha = 32'h0;
		ea = 32'h0;
		hb = 32'h0;
		eb = 32'h0;
		@(negedge clk_sys);
		pa = pin_a;
		pb = pin_b;
		repeat (512) begin
			@(negedge clk_sys);
			ha = ha + pin_a;
			hb = hb + pin_b;
			ea = ea + (pin_a ^ pa);
			eb = eb + (pin_b ^ pb);
			pa = pin_a;
			pb = pin_b;
		end
		@(posedge clk_sys);
	endtask

	// pins driven, port data 1 shows on disconnected channels
	task automatic run_case(input logic [7:0] ca, cb, ma, mb, input logic [31:0] ha, ea, hb, eb, input logic wf);
		logic [31:0] sa;
		logic [31:0] xa;
		logic [31:0] sb;
		logic [31:0] xb;
		do_reset();
		wr(`T8W_OFF_PORT, 32'h0000000F);
		wr(`T8W_OFF_CMP_A, {24'h0, ma});
		wr(`T8W_OFF_CMP_B, {24'h0, mb});
		wr(`T8W_OFF_CTRL_A, {24'h0, ca});
		wr(`T8W_OFF_CTRL_B, {24'h0, cb});
		repeat (100) @(posedge clk_sys);
		measure(sa, xa, sb, xb);
		chk("pin a high cycles", ha, sa);
		chk("pin a edges", ea, xa);
		chk("pin b high cycles", hb, sb);
		chk("pin b edges", eb, xb);
		wr(`T8W_OFF_CTRL_B, {24'h0, cb & 8'hFD});
		rd(`T8W_OFF_STATUS, d);
		chk_bit("wrap flag", wf, d[0]);
		wr(`T8W_OFF_STATUS, 32'h00000001);
		rd(`T8W_OFF_STATUS, d);
		chk_bit("wrap flag cleared", 1'b0, d[0]);
	endtask

	task automatic end_sim();
		if (error_cnt == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// ---------------------------------------------------------------
	// watchdog and main sequence
	// ---------------------------------------------------------------
	initial begin
		#500000;
		error_cnt++;
		end_sim();
	end

	initial begin
		error_cnt = 0;
		compares = 0;
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		rd(`T8W_OFF_CTRL_A, d);
		chk("ctrl a reset", 32'h00000000, d);
		wr(`T8W_OFF_CTRL_A, 32'hFFFFFFFF);
		rd(`T8W_OFF_CTRL_A, d);
		chk("ctrl a readback", 32'h000000F3, d);
		wr(`T8W_OFF_CMP_A, 32'h000000A5);
		rd(`T8W_OFF_CMP_A, d);
		chk("compare a readback", 32'h000000A5, d);
		apb(1'b0, 12'h040, 32'h00000000, d, e);
		chk_bit("unmapped read error", 1'b1, e);
		chk("unmapped read data", 32'h00000000, d);
		apb(1'b1, 12'h124, 32'h00000000, d, e);
		chk_bit("upper address error", 1'b1, e);
		rd(`T8W_OFF_CTRL_A, d);
		chk("ctrl a after refused write", 32'h000000F3, d);
		chk_bit("drive a off", 1'b1, ena_n);
		wr(`T8W_OFF_PORT, 32'h00000003);
		repeat (2) @(posedge clk_sys);
		chk_bit("drive a on", 1'b0, ena_n);
		chk_bit("drive b on", 1'b0, enb_n);
		// only documented modes and no channel b toggle code in pwm modes
		run_case(8'hA3, 8'h03, 8'h0F, 8'h05, 512, 0, 192, 64, 1'b1);
		run_case(8'hF3, 8'h03, 8'h0F, 8'h05, 0, 0, 320, 64, 1'b1);
		run_case(8'hB1, 8'h03, 8'h08, 8'h02, 512, 0, 384, 64, 1'b1);
		run_case(8'h21, 8'h03, 8'h08, 8'h02, 512, 0, 128, 64, 1'b1);
		run_case(8'hE1, 8'h03, 8'h08, 8'h08, 0, 0, 512, 0, 1'b1);
		run_case(8'h52, 8'h02, 8'h07, 8'h03, 256, 64, 256, 64, 1'b0);
		run_case(8'hB2, 8'h02, 8'h07, 8'h03, 0, 0, 512, 0, 1'b0);
		run_case(8'hE2, 8'h02, 8'h07, 8'h03, 512, 0, 0, 0, 1'b0);
		run_case(8'h40, 8'h02, 8'h03, 8'h00, 256, 2, 512, 0, 1'b1);
		run_case(8'h43, 8'h02, 8'h05, 8'h00, 512, 0, 512, 0, 1'b1);
		run_case(8'h43, 8'h03, 8'h0F, 8'h00, 256, 32, 512, 0, 1'b1);
		end_sim();
	end
endmodule

bind t8w_top t8w_top_monitor #(.ADDR_W(ADDR_W)) mon_u (.clk_sys(clk_sys), .rst(rst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
	.pslverr(pslverr), .chan_a_wave_out(chan_a_wave_out), .chan_a_drive_en_n(chan_a_drive_en_n),
	.chan_b_wave_out(chan_b_wave_out), .chan_b_drive_en_n(chan_b_drive_en_n), .wrap_flag(wrap_flag));
`default_nettype wire
